//--- hw/pbt_pkg.sv
/*
 * Package for the proximity offset and baseline tracking block: register
 * offsets, field positions, reset values and the carrier structs.
 * Assumes a byte-wide register port driven by the serial host bus decoder.
 */
package pbt_pkg;

    localparam logic [7:0] ADDR_CALIB_AVERAGE_CFG = 8'heb;
    localparam logic [7:0] ADDR_PROX_TRACKING_CFG = 8'hec;
    localparam logic [7:0] ADDR_STATUS            = 8'hee;
    localparam logic [7:0] ADDR_TRIM_LO           = 8'hc7;
    localparam logic [7:0] ADDR_TRIM_HI           = 8'hc8;
    localparam logic [7:0] ADDR_BASE_LO           = 8'hf0;
    localparam logic [7:0] ADDR_BASE_HI           = 8'hf1;
    localparam logic [7:0] ADDR_AVG_LO            = 8'hf2;
    localparam logic [7:0] ADDR_AVG_HI            = 8'hf3;

    // Field positions.
    localparam int BIT_DC_TO_BASE  = 7;
    localparam int BIT_ZERO_TRIM   = 6;
    localparam int BIT_TRACK_MIN   = 3;
    localparam int BIT_FLAG_TRIM   = 0;
    localparam int BIT_FLAG_BASE   = 1;

    localparam logic [7:0] RST_CALIB_AVERAGE_CFG = 8'h00;
    localparam logic [7:0] RST_PROX_TRACKING_CFG = 8'h0c;
    localparam logic [7:0] MASK_CALIB_AVERAGE_CFG = 8'h87;
    localparam logic [7:0] MASK_PROX_TRACKING_CFG = 8'h4f;
    localparam logic [8:0] TRIM_MIN = 9'h101;
    localparam logic [8:0] RST_TRIM = 9'h000;
    localparam logic [15:0] RST_BASE = 16'hffff;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pbt_reg_req_s;

    typedef struct packed {
        logic        valid;
        logic        calib;
        logic        calib_end;
        logic [15:0] data;
    } pbt_sample_s;

endpackage

//--- hw/pbt_tracker.sv
/*
 * Proximity offset trim and baseline tracking with sample averaging.
 * Assumes the proximity engine gives one pulse per conversion result and
 * a calib_end pulse when calibration finishes; register access is one cycle.
 */
// Functional notes
// - With zero-hit trim on, a zero proximity result decrements the offset unless it is at minimum.
// - An offset trim sets the trimmed flag and raises calibration irq if on.
// - With tracking on, a smaller average overwrites the baseline; a DC copy in the same cycle wins.
// - A tracking baseline replacement sets the moved flag and raises irq if enabled; the DC copy does not.
// - Baseline tracking enable resets to one; software may clear it.
// - Normal operation averages 2^N samples, N a three-bit field, reset 4.
// - After binary search, DC averaging uses 2^N measurements from its field.
// - Offset is nine-bit two's complement; high byte reads all zeros or ones.
// - With copy enabled, DC average loads the baseline at calibration end.
`timescale 1ns/10ps
module pbt_tracker (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset,
    input  wire pbt_pkg::pbt_reg_req_s i_reg,
    input  wire pbt_pkg::pbt_sample_s  i_sample,
    input  wire logic                  i_calib_irq_en,
    output logic [7:0]                 o_rdata,
    output logic [8:0]                 o_prox_signed_trim,
    output logic [15:0]                o_prox_baseline,
    output logic [15:0]                o_prox_average,
    output logic                       o_calibration_irq
);

    typedef struct packed {
        logic [7:0]  avg_cfg;
        logic [7:0]  trk_cfg;
        logic [8:0]  trim;
        logic [15:0] base;
        logic [15:0] avg;
        logic [15:0] dc_avg;
        logic [22:0] acc;
        logic [7:0]  cnt;
        logic        calib_mode;
        logic        flag_trim;
        logic        flag_base;
        logic        irq;
        logic [7:0]  rdata;
    } pbt_state_s;

    pbt_state_s st_r;
    pbt_state_s st_nxt;

    logic [2:0]  n_sel;
    logic [7:0]  target;
    logic [22:0] acc_base;
    logic [7:0]  cnt_base;
    logic [22:0] acc_sum;
    logic [15:0] mean;
    logic        zero_hit;
    logic        trim_ev;
    logic        base_ev;
    logic        done;

    always_comb begin
        st_nxt = st_r;
        n_sel    = i_sample.calib ? st_r.avg_cfg[2:0] : st_r.trk_cfg[2:0];
        target   = 8'(8'h01 << n_sel);
        // A sample of the other mode starts a fresh sum, so a calibration
        // pass never blends into the running proximity average.
        acc_base = (i_sample.calib == st_r.calib_mode) ? st_r.acc : '0;
        cnt_base = (i_sample.calib == st_r.calib_mode) ? st_r.cnt : '0;
        acc_sum  = acc_base + {7'h00, i_sample.data};
        mean     = 16'(acc_sum >> n_sel);
        done     = i_sample.valid && (cnt_base + 8'h01 >= target);
        zero_hit = i_sample.valid && (i_sample.data == 16'h0000) &&
                   st_r.trk_cfg[pbt_pkg::BIT_ZERO_TRIM] && !i_sample.calib;
        trim_ev  = zero_hit && (st_r.trim != pbt_pkg::TRIM_MIN);
        base_ev  = 1'b0;

        if (i_sample.valid) begin
            st_nxt.calib_mode = i_sample.calib;
            if (done) begin
                st_nxt.acc = '0;
                st_nxt.cnt = '0;
                if (i_sample.calib) begin
                    st_nxt.dc_avg = mean;
                end else begin
                    st_nxt.avg = mean;
                    if (st_r.trk_cfg[pbt_pkg::BIT_TRACK_MIN] &&
                        mean < st_r.base) begin
                        st_nxt.base = mean;
                        base_ev     = 1'b1;
                    end
                end
            end else begin
                st_nxt.acc = acc_sum;
                st_nxt.cnt = cnt_base + 8'h01;
            end
        end

        if (trim_ev) begin
            st_nxt.trim = st_r.trim - 9'h001;
        end

        if (i_sample.calib_end &&
            st_r.avg_cfg[pbt_pkg::BIT_DC_TO_BASE]) begin
            st_nxt.base = st_r.dc_avg;
        end

        st_nxt.rdata = 8'h00;
        if (i_reg.rd) begin
            unique case (i_reg.addr)
                pbt_pkg::ADDR_CALIB_AVERAGE_CFG: st_nxt.rdata = st_r.avg_cfg;
                pbt_pkg::ADDR_PROX_TRACKING_CFG: st_nxt.rdata = st_r.trk_cfg;
                pbt_pkg::ADDR_STATUS:
                    st_nxt.rdata = {6'h00, st_r.flag_base, st_r.flag_trim};
                pbt_pkg::ADDR_TRIM_LO:   st_nxt.rdata = st_r.trim[7:0];
                pbt_pkg::ADDR_TRIM_HI:   st_nxt.rdata = {8{st_r.trim[8]}};
                pbt_pkg::ADDR_BASE_LO:   st_nxt.rdata = st_r.base[7:0];
                pbt_pkg::ADDR_BASE_HI:   st_nxt.rdata = st_r.base[15:8];
                pbt_pkg::ADDR_AVG_LO:    st_nxt.rdata = st_r.avg[7:0];
                pbt_pkg::ADDR_AVG_HI:    st_nxt.rdata = st_r.avg[15:8];
                default:                 st_nxt.rdata = 8'h00;
            endcase
        end

        // Software writes lose to a same-cycle hardware update of the trim.
        if (i_reg.wr) begin
            unique case (i_reg.addr)
                // A half-filled sum would be judged against the new count,
                // so any change of the averaging setup starts over.
                pbt_pkg::ADDR_CALIB_AVERAGE_CFG: begin
                    st_nxt.avg_cfg = i_reg.wdata &
                                     pbt_pkg::MASK_CALIB_AVERAGE_CFG;
                    st_nxt.acc     = '0;
                    st_nxt.cnt     = '0;
                end
                pbt_pkg::ADDR_PROX_TRACKING_CFG: begin
                    st_nxt.trk_cfg = i_reg.wdata &
                                     pbt_pkg::MASK_PROX_TRACKING_CFG;
                    st_nxt.acc     = '0;
                    st_nxt.cnt     = '0;
                end
                pbt_pkg::ADDR_TRIM_LO: if (!trim_ev) begin
                    st_nxt.trim[7:0] = i_reg.wdata;
                end
                pbt_pkg::ADDR_TRIM_HI: if (!trim_ev) begin
                    st_nxt.trim[8] = i_reg.wdata[7];
                end
                pbt_pkg::ADDR_STATUS: begin
                    // Write one to clear; a new event in the same cycle wins.
                    if (i_reg.wdata[pbt_pkg::BIT_FLAG_TRIM]) begin
                        st_nxt.flag_trim = 1'b0;
                    end
                    if (i_reg.wdata[pbt_pkg::BIT_FLAG_BASE]) begin
                        st_nxt.flag_base = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        if (trim_ev) begin
            st_nxt.flag_trim = 1'b1;
        end
        if (base_ev) begin
            st_nxt.flag_base = 1'b1;
        end
        st_nxt.irq = i_calib_irq_en && (st_nxt.flag_trim || st_nxt.flag_base);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_r         <= '0;
            st_r.avg_cfg <= pbt_pkg::RST_CALIB_AVERAGE_CFG;
            st_r.trk_cfg <= pbt_pkg::RST_PROX_TRACKING_CFG;
            st_r.trim    <= pbt_pkg::RST_TRIM;
            st_r.base    <= pbt_pkg::RST_BASE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata            = st_r.rdata;
    assign o_prox_signed_trim = st_r.trim;
    assign o_prox_baseline    = st_r.base;
    assign o_prox_average     = st_r.avg;
    assign o_calibration_irq  = st_r.irq;

    // A zero result from proximity sensing with the trim switched on.
    sequence s_zero_result;
        i_sample.valid && !i_sample.calib && i_sample.data == 16'h0000 &&
        st_r.trk_cfg[pbt_pkg::BIT_ZERO_TRIM];
    endsequence

    sequence s_normal_sample;
        i_sample.valid && !i_sample.calib;
    endsequence

    AST_TRIM_DEC: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        s_zero_result ##0 st_r.trim != pbt_pkg::TRIM_MIN |=>
        st_r.trim == $past(st_r.trim) - 9'h001)
        else $error("Offset not decremented on zero hit.");
    AST_TRIM_FLAG: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        trim_ev |=> st_r.flag_trim &&
        o_calibration_irq == $past(i_calib_irq_en))
        else $error("Trim flag or irq missing.");
    AST_BASE_MIN: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        base_ev && !(i_sample.calib_end &&
        st_r.avg_cfg[pbt_pkg::BIT_DC_TO_BASE]) |=>
        st_r.base == st_r.avg && st_r.base < $past(st_r.base))
        else $error("Baseline not lowered to the average.");
    AST_BASE_FLAG: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        base_ev |=> st_r.flag_base &&
        o_calibration_irq == $past(i_calib_irq_en))
        else $error("Baseline flag or irq missing.");
    AST_TRACK_RESET: assert property (
        @(posedge i_core_clk)
        $past(i_reset) |-> st_r.trk_cfg[pbt_pkg::BIT_TRACK_MIN])
        else $error("Tracking enable not set after reset.");
    AST_TRACK_OFF: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        s_normal_sample ##0 !st_r.trk_cfg[pbt_pkg::BIT_TRACK_MIN] &&
        !i_sample.calib_end |=> st_r.base == $past(st_r.base))
        else $error("Baseline moved with tracking off.");
    AST_AVG_CNT: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        st_r.cnt < 8'h80)
        else $error("Average count overran.");
    AST_AVG_SKIP: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        s_normal_sample ##0 st_r.trk_cfg[2:0] == 3'h0 |=>
        o_prox_average == $past(i_sample.data))
        else $error("Unaveraged sample not passed through.");
    AST_TRIM_SIGN: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        i_reg.rd && i_reg.addr == pbt_pkg::ADDR_TRIM_HI |=>
        o_rdata == 8'h00 || o_rdata == 8'hff)
        else $error("Trim high byte not a sign.");
    AST_DC_BASE: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        i_sample.calib_end && st_r.avg_cfg[pbt_pkg::BIT_DC_TO_BASE] |=>
        st_r.base == $past(st_r.dc_avg))
        else $error("DC average not copied to baseline.");
    AST_TRIM_SAT: assert property (
        @(posedge i_core_clk) disable iff (i_reset)
        s_zero_result ##0 st_r.trim == pbt_pkg::TRIM_MIN && !i_reg.wr |=>
        st_r.trim == pbt_pkg::TRIM_MIN)
        else $error("Offset wrapped past minimum.");

endmodule

//--- tb/pbt_tracker_tb.sv
/*
 * Self-checking bench for the offset trim and baseline tracking block.
 * Assumes the design's one-cycle register strobes and sample pulses.
 */
`timescale 1ns/10ps
module pbt_tracker_tb;
    logic                  clk      = 1'b0;
    logic                  rst      = 1'b1;
    logic                  irq_en   = 1'b1;
    pbt_pkg::pbt_reg_req_s req      = '0;
    pbt_pkg::pbt_sample_s  smp_in   = '0;
    logic [7:0]            rdata;
    logic [8:0]            trim;
    logic [15:0]           base;
    logic [15:0]           avg;
    logic                  irq;
    logic [7:0]            d;
    int                    errors   = 0;
    int                    n_checks = 0;

    always #20 clk = ~clk;

    pbt_tracker u_pbt_tracker (
        .i_core_clk         (clk),
        .i_reset            (rst),
        .i_reg              (req),
        .i_sample           (smp_in),
        .i_calib_irq_en     (irq_en),
        .o_rdata            (rdata),
        .o_prox_signed_trim (trim),
        .o_prox_baseline    (base),
        .o_prox_average     (avg),
        .o_calibration_irq  (irq)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        req = '{1'b1, 1'b0, a, v};
        @(negedge clk);
        req = '0;
    endtask

    // Read data is registered, so it is sampled one cycle after the strobe is raised.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req = '0;
        v = rdata;
    endtask

    task automatic smp(input logic [15:0] v, input logic c, input logic e);
        @(negedge clk);
        smp_in = '{~e, c, e, v};
        @(negedge clk);
        smp_in = '0;
        repeat (2) @(negedge clk);
    endtask

    task automatic t_reset;
        rd(8'heb, d);
        chk(16'(d), 16'h0000);
        rd(8'hec, d);
        chk(16'(d), 16'h000c);
        rd(8'h55, d);
        chk(16'(d), 16'h0000);
        chk(base, 16'hffff);
        chk(avg, 16'h0000);
        chk(16'(irq), 16'h0000);
        chk(16'(trim), 16'h0000);
        $display("reset test done");
    endtask

    task automatic t_track;
        wr(8'hec, 8'h08);
        smp(16'h0005, 1'b0, 1'b0);
        chk(avg, 16'h0005);
        chk(base, 16'h0005);
        chk(16'(irq), 16'h0001);
        rd(8'hee, d);
        chk(16'(d), 16'h0002);
        irq_en = 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(irq), 16'h0000);
        irq_en = 1'b1;
        smp(16'h0009, 1'b0, 1'b0);
        chk(avg, 16'h0009);
        chk(base, 16'h0005);
        wr(8'hee, 8'h03);
        $display("tracking test done");
    endtask

    task automatic t_trim;
        wr(8'hec, 8'h40);
        smp(16'h0000, 1'b0, 1'b0);
        chk(16'(trim), 16'h01ff);
        // Tracking is off here, so the smaller average leaves it alone.
        chk(base, 16'h0005);
        chk(avg, 16'h0000);
        rd(8'hee, d);
        chk(16'(d), 16'h0001);
        chk(16'(irq), 16'h0001);
        rd(8'hc8, d);
        chk(16'(d), 16'h00ff);
        // Load -255, then a zero hit must not wrap the offset positive.
        wr(8'hc7, 8'h01);
        wr(8'hc8, 8'hff);
        smp(16'h0000, 1'b0, 1'b0);
        chk(16'(trim), 16'h0101);
        wr(8'hee, 8'h03);
        $display("trim test done");
    endtask

    task automatic t_avg;
        wr(8'hec, 8'h01);
        smp(16'h0004, 1'b0, 1'b0);
        smp(16'h0008, 1'b0, 1'b0);
        chk(avg, 16'h0006);
        chk(base, 16'h0005);
        wr(8'heb, 8'h81);
        smp(16'h000a, 1'b1, 1'b0);
        smp(16'h0014, 1'b1, 1'b0);
        smp(16'h0000, 1'b0, 1'b1);
        chk(base, 16'h000f);
        $display("averaging test done");
    endtask

    // Tracking was switched off above, so reset must bring it back.
    task automatic t_rerun;
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(8'hec, d);
        chk(16'(d), 16'h000c);
        rd(8'hee, d);
        chk(16'(d), 16'h0000);
        chk(base, 16'hffff);
        chk(16'(trim), 16'h0000);
        $display("reset rerun test done");
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_track;
        t_trim;
        t_avg;
        t_rerun;
        close_out;
    end

    // The tests need well under a thousand cycles.
    initial begin
        #100us;
        errors++;
        close_out;
    end
endmodule
